// ### ssf_dma_model.sv
// ssf_dma_model: dma controller side, one done pulse per channel
// assumes: start is a one-cycle pulse; a delay of 0 leaves that channel idle
module ssf_dma_model
  import ssf_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // channel start
  input wire logic i_start,
  input wire logic [7:0] i_tx_dly,
  input wire logic [7:0] i_rx_dly,
  // completion
  output ssf_dma_t o_dma
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_cnt;
  logic [7:0] rx_cnt;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_cnt <= 8'h00;
      rx_cnt <= 8'h00;
      o_dma <= '0;
    end else begin
      // done when the channel count runs out
      o_dma.tx_done <= tx_cnt == 8'h01;
      o_dma.rx_done <= rx_cnt == 8'h01;
      tx_cnt <= i_start ? i_tx_dly : ((tx_cnt == 8'h00) ? 8'h00 : tx_cnt - 8'h01);
      rx_cnt <= i_start ? i_rx_dly : ((rx_cnt == 8'h00) ? 8'h00 : rx_cnt - 8'h01);
    end
  end
endmodule : ssf_dma_model

// ### ssf_pkg.sv
// ssf_pkg: register map, field positions and carrier types for the spi status flags block
// assumes: included before every other file of the block
package ssf_pkg;
  localparam logic [7:0] SSF_STATUS_OFS = 8'h10;
  localparam logic [7:0] SSF_COUNT_OFS = 8'h14;
  localparam logic [7:0] SSF_TRIG_OFS = 8'h1C;
  localparam logic [7:0] SSF_CTRL_OFS = 8'h40;
  localparam int SSF_TC_BIT = 0;
  localparam int SSF_DMAC_BIT = 1;
  localparam int SSF_TXERR_BIT = 2;
  localparam int SSF_RXERR_BIT = 3;
  localparam int SSF_PERR_BIT = 4;
  localparam int SSF_TXFULL_BIT = 8;
  localparam int SSF_TXEMPTY_BIT = 9;
  localparam int SSF_TXREQ_BIT = 10;
  localparam int SSF_CTL_DMA_BIT = 0;
  localparam int SSF_CTL_DESC_BIT = 1;
  localparam int SSF_CTL_CLOSE_BIT = 2;
  localparam int SSF_CTL_STOP_BIT = 3;
  localparam int SSF_CTL_TXDMA_BIT = 4;
  localparam int SSF_CTL_RXDMA_BIT = 5;
  localparam logic [5:0] SSF_CTRL_RST = 6'h00;
  localparam logic [5:0] SSF_CTRL_MASK = 6'h3F;
  localparam int SSF_CNT_W = 16;
  localparam int SSF_TX_DEPTH = 64;

  typedef enum logic [1:0] {SSF_MODE_MANUAL, SSF_MODE_DMA, SSF_MODE_DESC} ssf_mode_t;

  // engine events, all one-cycle pulses
  typedef struct packed {
    logic tx_push;
    logic tx_pop;
    logic rx_read_empty;
    logic prog_err;
    logic len_reached;
    logic desc_done;
    logic desc_last;
    logic byte_done;
  } ssf_evt_t;

  // dma completion pulses per channel
  typedef struct packed {
    logic tx_done;
    logic rx_done;
  } ssf_dma_t;
endpackage : ssf_pkg

// ### ssf_status.sv
// ssf_status: lower status flags of the spi host controller status register
// assumes: single clock, engine and dma events are one-cycle pulses on i_clk
// What this block does
// - transmit request flag bit 10 sets while tx count <= trigger; write-1-clear
// - transmit empty bit 9 read-only, 1 while buffer empty, resets 1
// - transmit full bit 8 read-only, 1 while buffer full, resets 0
// - programming error bit 4 sets on illegal configuration; write-1-clear
// - receive underflow bit 3 sets on read of empty receive buffer
// - transmit overflow bit 2 sets on write to full transmit buffer
// - dma complete bit 1 sets when dma controller signals completion
// - dma raises completion on transfer close or channel count exhausted
// - with both dma directions active, wait for both completions
// - close-transfer option sets dma complete and transfer complete together
// - descriptor mode does not suppress dma complete per descriptor
// - manual mode sets transfer complete when length reached
// - dma mode sets transfer complete with dma complete
// - descriptor mode sets transfer complete on last descriptor, and with dma complete under close-transfer
// - stop finishes current byte then sets transfer complete
// - dma complete is meaningless without dma enabled
// - transmit byte count tracks valid bytes in transmit buffer
// - trigger level zero disables transmit request
//
// Design decision made here: strobed register access.
module ssf_status
  import ssf_pkg::*;
#(
  parameter int TX_DEPTH = SSF_TX_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // engine and dma events
  input wire ssf_evt_t i_evt,
  input wire ssf_dma_t i_dma,
  // flags out
  output logic o_xfer_done,
  output logic o_dma_done
);
  logic [SSF_CNT_W-1:0] tx_count;
  logic tx_empty;
  logic tx_full;
  logic [SSF_CNT_W-1:0] tx_trig;
  logic [SSF_CNT_W-1:0] next_tx_trig;
  logic [5:0] ctrl;
  logic [5:0] next_ctrl;
  logic stop_pend;
  logic next_stop_pend;
  logic [1:0] dma_seen;
  logic [1:0] next_dma_seen;
  logic [31:0] next_rdata;
  logic next_xfer_done;
  logic next_dma_done;
  ssf_mode_t mode;
  logic wr_stat;
  logic [4:0] set_vec;
  logic [4:0] clr_vec;
  logic [4:0] flag_vec;
  logic txreq_set;
  logic txreq_flag;
  logic tx_push_ok;
  logic dma_fire;
  logic want_tx;
  logic want_rx;
  logic [1:0] seen_now;

  ssf_tx_count #(
    .DEPTH(TX_DEPTH)
  ) u_txc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_push(i_evt.tx_push),
    .i_pop(i_evt.tx_pop),
    .o_count(tx_count),
    .o_empty(tx_empty),
    .o_full(tx_full)
  );

  always_comb begin
    if (ctrl[SSF_CTL_DESC_BIT]) begin
      mode = SSF_MODE_DESC;
    end else if (ctrl[SSF_CTL_DMA_BIT]) begin
      mode = SSF_MODE_DMA;
    end else begin
      mode = SSF_MODE_MANUAL;
    end
  end

  // dma completion collection across both directions
  always_comb begin
    want_tx = ctrl[SSF_CTL_TXDMA_BIT];
    want_rx = ctrl[SSF_CTL_RXDMA_BIT];
    seen_now = dma_seen | {i_dma.rx_done, i_dma.tx_done};
    dma_fire = 1'b0;
    next_dma_seen = seen_now;
    if (mode != SSF_MODE_MANUAL) begin
      if (want_tx && want_rx) begin
        dma_fire = seen_now[0] && seen_now[1];
      end else begin
        dma_fire = i_dma.tx_done || i_dma.rx_done;
      end
    end
    if (dma_fire || mode == SSF_MODE_MANUAL) begin
      next_dma_seen = 2'h0;
    end
  end

  // stop: wait for the byte in flight
  always_comb begin
    next_stop_pend = stop_pend;
    if (stop_pend && i_evt.byte_done) begin
      next_stop_pend = 1'b0;
    end else if (i_wr && i_addr == SSF_CTRL_OFS && i_wdata[SSF_CTL_STOP_BIT]) begin
      next_stop_pend = 1'b1;
    end
  end

  assign tx_push_ok = i_evt.tx_push && tx_full;
  assign wr_stat = i_wr && (i_addr == SSF_STATUS_OFS);

  always_comb begin
    set_vec = 5'h00;
    set_vec[SSF_PERR_BIT] = i_evt.prog_err;
    set_vec[SSF_RXERR_BIT] = i_evt.rx_read_empty;
    set_vec[SSF_TXERR_BIT] = tx_push_ok;
    set_vec[SSF_DMAC_BIT] = dma_fire;
    set_vec[SSF_TC_BIT] = stop_pend && i_evt.byte_done;
    case (mode)
      SSF_MODE_MANUAL: begin
        if (i_evt.len_reached) begin
          set_vec[SSF_TC_BIT] = 1'b1;
        end
      end
      SSF_MODE_DMA: begin
        if (dma_fire) begin
          set_vec[SSF_TC_BIT] = 1'b1;
        end
      end
      default: begin
        if (i_evt.desc_done && i_evt.desc_last) begin
          set_vec[SSF_TC_BIT] = 1'b1;
        end
        if (dma_fire && ctrl[SSF_CTL_CLOSE_BIT]) begin
          set_vec[SSF_TC_BIT] = 1'b1;
        end
      end
    endcase
    clr_vec = wr_stat ? i_wdata[4:0] : 5'h00;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_flag
      ssf_w1c_flag u_flag (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_set(set_vec[gi]),
        .i_clr(clr_vec[gi]),
        .o_flag(flag_vec[gi])
      );
    end
  endgenerate

  assign txreq_set = (tx_trig != '0) && (tx_count <= tx_trig);

  ssf_w1c_flag u_txreq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_set(txreq_set),
    .i_clr(wr_stat && i_wdata[SSF_TXREQ_BIT]),
    .o_flag(txreq_flag)
  );

  // configuration registers and read mux
  always_comb begin
    next_ctrl = ctrl;
    next_tx_trig = tx_trig;
    next_rdata = 32'h0000_0000;
    if (i_wr) begin
      if (i_addr == SSF_CTRL_OFS) begin
        next_ctrl = i_wdata[5:0] & SSF_CTRL_MASK;
        next_ctrl[SSF_CTL_STOP_BIT] = 1'b0;
      end else if (i_addr == SSF_TRIG_OFS) begin
        next_tx_trig = i_wdata[SSF_CNT_W-1:0];
      end
    end
    if (i_rd) begin
      if (i_addr == SSF_STATUS_OFS) begin
        next_rdata[4:0] = flag_vec;
        next_rdata[SSF_TXFULL_BIT] = tx_full;
        next_rdata[SSF_TXEMPTY_BIT] = tx_empty;
        next_rdata[SSF_TXREQ_BIT] = txreq_flag;
      end else if (i_addr == SSF_COUNT_OFS) begin
        next_rdata[SSF_CNT_W-1:0] = tx_count;
      end else if (i_addr == SSF_TRIG_OFS) begin
        next_rdata[SSF_CNT_W-1:0] = tx_trig;
      end else if (i_addr == SSF_CTRL_OFS) begin
        next_rdata[5:0] = ctrl;
        next_rdata[SSF_CTL_STOP_BIT] = stop_pend;
      end else begin
        next_rdata = 32'h0000_0000;
      end
    end
    next_xfer_done = flag_vec[SSF_TC_BIT];
    next_dma_done = flag_vec[SSF_DMAC_BIT];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= SSF_CTRL_RST;
      tx_trig <= '0;
      stop_pend <= 1'b0;
      dma_seen <= 2'h0;
      o_rdata <= 32'h0000_0000;
      o_xfer_done <= 1'b0;
      o_dma_done <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      tx_trig <= next_tx_trig;
      stop_pend <= next_stop_pend;
      dma_seen <= next_dma_seen;
      o_rdata <= next_rdata;
      o_xfer_done <= next_xfer_done;
      o_dma_done <= next_dma_done;
    end
  end
endmodule : ssf_status

// ### ssf_status_chk.sv
// ssf_status_chk: port assertions for ssf_status
// assumes: bound into ssf_status, status flags land one edge after their cause, o_dma_done and o_xfer_done two edges after
module ssf_status_chk
  import ssf_pkg::*;
#(
  parameter int TX_DEPTH = SSF_TX_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // events and flags
  input wire ssf_evt_t i_evt,
  input wire ssf_dma_t i_dma,
  input wire logic o_xfer_done,
  input wire logic o_dma_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic st_rd;
  logic [5:0] ctl;
  logic [5:0] next_ctl;
  assign st_rd = i_rd && i_addr == SSF_STATUS_OFS;
  // mirror of the mode bits
  assign next_ctl = (i_wr && i_addr == SSF_CTRL_OFS) ? i_wdata[5:0] : ctl;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl <= 6'h00;
    end else begin
      ctl <= next_ctl;
    end
  end
  // read one or two cycles after the event, with no clear write in between
  AST_PERR: assert property (st_rd && ($past(i_evt.prog_err)
    || ($past(i_evt.prog_err, 2) && !$past(i_wr))) |=> o_rdata[4])
    else $error("programming error flag not set");
  AST_RXERR: assert property (st_rd && ($past(i_evt.rx_read_empty)
    || ($past(i_evt.rx_read_empty, 2) && !$past(i_wr))) |=> o_rdata[3])
    else $error("underflow flag not set");
  AST_RSVD: assert property ($past(st_rd) |-> o_rdata[7:5] == 3'h0)
    else $error("reserved bits not zero");
  AST_DMA_SET: assert property ($rose(o_dma_done) |-> $past(i_dma != 2'h0, 2))
    else $error("dma flag set without completion");
  AST_XFER_SET: assert property ($rose(o_xfer_done) |-> $past(i_evt.len_reached
    | i_evt.desc_done | i_evt.byte_done | (i_dma != 2'h0), 2))
    else $error("transfer flag set without cause");
  AST_DMA_HOLD: assert property ($fell(o_dma_done) |->
    $past(i_wr && i_addr == SSF_STATUS_OFS && i_wdata[1], 2))
    else $error("dma flag dropped without clear");
  AST_XFER_HOLD: assert property ($fell(o_xfer_done) |->
    $past(i_wr && i_addr == SSF_STATUS_OFS && i_wdata[0], 2))
    else $error("transfer flag dropped without clear");
  AST_TC_DMA: assert property (ctl[0] && (!ctl[1] || ctl[2]) && $rose(o_dma_done)
    |-> o_xfer_done)
    else $error("transfer flag not set with dma flag");
endmodule : ssf_status_chk

// ### ssf_status_tb_top.sv
// ssf_status_tb_top: directed bench for ssf_status with a dma partner
// assumes: package, design, partner and checker compiled before this file
module ssf_status_tb_top import ssf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst_n, i_wr, i_rd, start, o_xfer_done, o_dma_done;
  logic [7:0] i_addr, tx_dly, rx_dly;
  logic [31:0] i_wdata, o_rdata;
  ssf_evt_t i_evt;
  ssf_dma_t i_dma;
  int n_errors = 0;
  int check_count = 0;
  ssf_status #(.TX_DEPTH(4)) dut_u (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_evt, .i_dma, .o_xfer_done, .o_dma_done);
  ssf_dma_model dma_u (.i_clk, .i_rst_n, .i_start(start), .i_tx_dly(tx_dly),
    .i_rx_dly(rx_dly), .o_dma(i_dma));
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic drv(logic w, logic [7:0] a, logic [31:0] d, ssf_evt_t e);
    @(posedge i_clk);
    i_wr <= w;
    i_addr <= a;
    i_wdata <= d;
    i_evt <= e;
    @(posedge i_clk);
    i_wr <= 1'h0;
    i_evt <= 8'h00;
  endtask : drv
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1;
    chk($sformatf("reg %h", a), exp, o_rdata);
  endtask : rd
  task automatic go(logic [7:0] t, logic [7:0] r);
    @(posedge i_clk);
    start <= 1'h1;
    tx_dly <= t;
    rx_dly <= r;
    @(posedge i_clk);
    start <= 1'h0;
  endtask : go
  task automatic wait_dma;
    for (int k = 0; k < 40 && o_dma_done !== 1'h1; k++) begin
      @(posedge i_clk);
      #1;
    end
    chk("dma_done", 32'h1, {31'h0, o_dma_done});
    if (o_dma_done !== 1'h1) begin
      give_verdict();
    end
  endtask : wait_dma
  task automatic t_reset;
    rd(SSF_STATUS_OFS, 32'h200);
    rd(SSF_COUNT_OFS, 32'h0);
    rd(SSF_TRIG_OFS, 32'h0);
    rd(8'h3C, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_err;
    drv(1'h0, 8'h00, 32'h0, 8'h30);
    rd(SSF_STATUS_OFS, 32'h218);
    drv(1'h1, SSF_STATUS_OFS, 32'h0, 8'h00);
    rd(SSF_STATUS_OFS, 32'h218);
    drv(1'h1, SSF_STATUS_OFS, 32'h18, 8'h10);
    rd(SSF_STATUS_OFS, 32'h210);
    drv(1'h1, SSF_STATUS_OFS, 32'hFFFFFFFF, 8'h00);
    rd(SSF_STATUS_OFS, 32'h200);
    $display("t_err done");
  endtask : t_err
  task automatic t_tx;
    drv(1'h1, SSF_TRIG_OFS, 32'h2, 8'h00);
    drv(1'h0, 8'h00, 32'h0, 8'h80);
    rd(SSF_COUNT_OFS, 32'h1);
    rd(SSF_STATUS_OFS, 32'h400);
    repeat (3) drv(1'h0, 8'h00, 32'h0, 8'h80);
    rd(SSF_STATUS_OFS, 32'h500);
    drv(1'h1, SSF_STATUS_OFS, 32'h400, 8'h00);
    rd(SSF_STATUS_OFS, 32'h100);
    drv(1'h0, 8'h00, 32'h0, 8'h80);
    rd(SSF_STATUS_OFS, 32'h104);
    rd(SSF_COUNT_OFS, 32'h4);
    drv(1'h1, SSF_STATUS_OFS, 32'h4, 8'h00);
    drv(1'h1, SSF_TRIG_OFS, 32'h0, 8'h00);
    repeat (4) drv(1'h0, 8'h00, 32'h0, 8'h40);
    rd(SSF_STATUS_OFS, 32'h200);
    $display("t_tx done");
  endtask : t_tx
  task automatic t_modes;
    drv(1'h0, 8'h00, 32'h0, 8'h08);
    rd(SSF_STATUS_OFS, 32'h201);
    chk("xfer_done", 32'h1, {31'h0, o_xfer_done});
    drv(1'h1, SSF_STATUS_OFS, 32'h1, 8'h00);
    drv(1'h1, SSF_CTRL_OFS, 32'h31, 8'h00);
    go(8'h02, 8'h0C);
    repeat (6) @(posedge i_clk);
    rd(SSF_STATUS_OFS, 32'h200);
    wait_dma();
    rd(SSF_STATUS_OFS, 32'h203);
    drv(1'h1, SSF_STATUS_OFS, 32'h3, 8'h00);
    drv(1'h1, SSF_CTRL_OFS, 32'h3, 8'h00);
    drv(1'h0, 8'h00, 32'h0, 8'h04);
    rd(SSF_STATUS_OFS, 32'h200);
    go(8'h01, 8'h00);
    wait_dma();
    rd(SSF_STATUS_OFS, 32'h202);
    drv(1'h0, 8'h00, 32'h0, 8'h06);
    rd(SSF_STATUS_OFS, 32'h203);
    drv(1'h1, SSF_STATUS_OFS, 32'h3, 8'h00);
    drv(1'h1, SSF_CTRL_OFS, 32'h7, 8'h00);
    go(8'h01, 8'h00);
    wait_dma();
    rd(SSF_STATUS_OFS, 32'h203);
    drv(1'h1, SSF_STATUS_OFS, 32'h3, 8'h00);
    drv(1'h1, SSF_CTRL_OFS, 32'h8, 8'h00);
    rd(SSF_CTRL_OFS, 32'h8);
    drv(1'h0, 8'h00, 32'h0, 8'h01);
    rd(SSF_STATUS_OFS, 32'h201);
    rd(SSF_CTRL_OFS, 32'h0);
    go(8'h01, 8'h00);
    repeat (3) @(posedge i_clk);
    rd(SSF_STATUS_OFS, 32'h201);
    $display("t_modes done");
  endtask : t_modes
  initial begin
    i_clk = 1'h0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    i_rst_n = 1'h0;
    i_wr = 1'h0;
    i_rd = 1'h0;
    start = 1'h0;
    i_addr = 8'h00;
    tx_dly = 8'h00;
    rx_dly = 8'h00;
    i_wdata = 32'h0;
    i_evt = 8'h00;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'h1;
    t_reset();
    t_err();
    t_tx();
    t_modes();
    give_verdict();
  end
endmodule : ssf_status_tb_top
bind ssf_status ssf_status_chk #(.TX_DEPTH(TX_DEPTH)) chk_u (.i_clk, .i_rst_n, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_evt, .i_dma, .o_xfer_done, .o_dma_done);

// ### ssf_tx_count.sv
// ssf_tx_count: transmit buffer occupancy counter with empty and full
// assumes: push is never taken when full, pop never when empty
module ssf_tx_count
  import ssf_pkg::*;
#(
  parameter int DEPTH = SSF_TX_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // buffer events
  input wire logic i_push,
  input wire logic i_pop,
  // state
  output logic [SSF_CNT_W-1:0] o_count,
  output logic o_empty,
  output logic o_full
);
  localparam logic [SSF_CNT_W-1:0] DEPTH_C = SSF_CNT_W'(DEPTH);
  logic [SSF_CNT_W-1:0] next_count;
  logic do_push;
  logic do_pop;

  always_comb begin
    do_push = i_push && (o_count != DEPTH_C);
    do_pop = i_pop && (o_count != '0);
    next_count = o_count;
    if (do_push && !do_pop) begin
      next_count = o_count + 16'h0001;
    end else if (do_pop && !do_push) begin
      next_count = o_count - 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count <= '0;
    end else begin
      o_count <= next_count;
    end
  end

  assign o_empty = (o_count == '0);
  assign o_full = (o_count == DEPTH_C);
endmodule : ssf_tx_count

// ### ssf_w1c_flag.sv
// ssf_w1c_flag: one sticky write-one-to-clear flag
// assumes: set and clear are single-cycle pulses on i_clk
module ssf_w1c_flag
  import ssf_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_set,
  input wire logic i_clr,
  // state
  output logic o_flag
);
  logic next_flag;

  always_comb begin
    next_flag = o_flag;
    if (i_set) begin
      next_flag = 1'b1;
    end else if (i_clr) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flag <= 1'b0;
    end else begin
      o_flag <= next_flag;
    end
  end
endmodule : ssf_w1c_flag
